// File: logic/adcf_map.svh
// Register offsets, field positions and reset values of the converter control block.
// Included by the design only; holds definitions only.
`ifndef ADCF_MAP_SVH
`define ADCF_MAP_SVH
`define ADCF_OFS_CONTROL 4'h0
`define ADCF_OFS_STATUS 4'h4
`define ADCF_OFS_RES_HIGH 4'h8
`define ADCF_OFS_RES_LOW 4'hC
`define ADCF_CTL_POWER_BIT 7
`define ADCF_CTL_JUSTIFY_BIT 6
`define ADCF_CTL_EIGHT_BIT 5
`define ADCF_CTL_SIGNED_BIT 4
`define ADCF_CTL_PRS_MSB 3
`define ADCF_STS_DONE_BIT 7
`define ADCF_STS_IRQEN_BIT 6
`define ADCF_CTL_RESET 8'h00
`define ADCF_STS_RESET 8'h00
`define ADCF_RES_RESET 8'h00
`endif

// File: logic/adcf_pkg.sv
// Types shared by the converter control block.
// Needs no include file; adcf_map.svh is included by the design.
package adcf_pkg;
    typedef enum logic [1:0] {ADCF_OFF, ADCF_IDLE, ADCF_BUSY} adcf_state_e;
    typedef logic [7:0] adcf_byte_t;
endpackage

// File: logic/adcf_control.sv
// Control, completion flag, interrupt and result formatting of a 10-bit converter.
// Assumes an Avalon-MM master on core_clk and a conversion core that pulses sar_done with sar_data valid.
// Operation
// R01 - Interrupt at completion, results already loaded
// R02 - Interrupt held while done flag set
// R03 - Status register write clears done flag
// R04 - Result register read clears done flag
// R05 - Software polls flag when interrupt disabled
// R06 - Control write aborts, starts nothing
// R07 - Bit 7 power on; clearing aborts
// R08 - Bit 6 selects left/right justification
// R09 - Bit 5 selects 8-bit result high
// R10 - 8-bit mode ignores justification select; the code skips the signed MSB inversion in 8-bit mode when bit 6 is set
// R11 - Bit 4 signed: invert result MSB
// R12 - Signed honoured only when left-justified
// R13 - Signed ranges 0x200-0x1FF, 0x80-0x7F
// R14 - Bits 3:0 select clock prescaler
// R15 - Right-justified full scale 0x03:0xFF
// R16 - Left full scale 0xFF:0xC0, signed 0x7F:0xC0
// R17 - 8-bit signed full 0x7F, zero 0x80
// R18 - Division factor twice select plus two
// R19 - Status write cancels interrupt, starts conversion
// R20 - Reset aborts, clears flag, powers down
// R21 - Unused result bits read zero
// R22 - Flag set wins over coincident clear
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "adcf_map.svh"

module adcf_control
    import adcf_pkg::*;
#(
    parameter int DATA_W = 10
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sar_done,
    input wire logic [DATA_W-1:0] sar_data,
    output logic conv_start,
    output logic conv_abort,
    output logic conv_clk,
    output logic converter_power_on,
    output logic conv_irq
);

    // ==========================================================
    // Result formatting
    function automatic logic [15:0] fmt_result(input logic [9:0] raw, input logic eight, input logic rjust,
                                               input logic signed_select);
        logic [9:0] v;
        v = raw;
        if (signed_select && !rjust)
            v[9] = ~v[9]; // R11 R12 R13
        if (eight)
            fmt_result = {v[9:2], 8'h00}; // R09 R10 R17 R21
        else if (rjust)
            fmt_result = {6'h00, raw}; // R08 R15 R21
        else
            fmt_result = {v, 6'h00}; // R08 R16
    endfunction

    // ==========================================================
    // State
    adcf_state_e state_r, state_nxt;
    adcf_byte_t ctl_r, res_hi_r, res_lo_r;
    logic irq_en_r, done_r, done_nxt;
    logic [31:0] rdata_r;
    logic wait_r;
    logic start_r, abort_r, cclk_r, pwr_r, irq_r;
    logic [3:0] div_cnt_r;

    // ==========================================================
    // Bus decode: one wait cycle, access takes effect when waitrequest is low
    wire req = avs_read || avs_write;
    wire acc = req && !wait_r;
    wire lane0 = avs_byteenable[0];
    wire wr_ctl = acc && avs_write && lane0 && avs_address == `ADCF_OFS_CONTROL;
    wire wr_sts = acc && avs_write && lane0 && avs_address == `ADCF_OFS_STATUS;
    wire rd_res = acc && avs_read && (avs_address == `ADCF_OFS_RES_HIGH || avs_address == `ADCF_OFS_RES_LOW);
    wire [7:0] ctl_wd = avs_writedata[7:0];
    wire pwr_wd = ctl_wd[`ADCF_CTL_POWER_BIT];
    wire [3:0] clock_prescale_select = ctl_r[`ADCF_CTL_PRS_MSB:0]; // R14
    wire finish = state_r == ADCF_BUSY && sar_done && !wr_ctl;
    wire [15:0] res_fmt = fmt_result(sar_data[9:0], ctl_r[`ADCF_CTL_EIGHT_BIT], ctl_r[`ADCF_CTL_JUSTIFY_BIT],
                                     ctl_r[`ADCF_CTL_SIGNED_BIT]);
    wire [7:0] sts_rd = {done_r, irq_en_r, 6'h00};
    wire [7:0] rd_byte = avs_address == `ADCF_OFS_CONTROL ? ctl_r :
                         avs_address == `ADCF_OFS_STATUS ? sts_rd :
                         avs_address == `ADCF_OFS_RES_HIGH ? res_hi_r :
                         avs_address == `ADCF_OFS_RES_LOW ? res_lo_r : 8'h00;
    // Compare with >= so a smaller prescale never runs the counter round to 15
    wire div_wrap = div_cnt_r >= clock_prescale_select;

    // Set wins: a completion in the clearing cycle must not be lost
    always_comb
    begin
        done_nxt = done_r;
        if (wr_sts || rd_res)
            done_nxt = 1'b0; // R03 R04 R19
        if (finish)
            done_nxt = 1'b1; // R22
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ADCF_OFF:
                if (wr_ctl && pwr_wd)
                    state_nxt = ADCF_IDLE; // R07
            ADCF_IDLE:
                if (wr_ctl && !pwr_wd)
                    state_nxt = ADCF_OFF;
                else if (wr_sts)
                    state_nxt = ADCF_BUSY; // R19
            ADCF_BUSY:
                if (wr_ctl)
                    state_nxt = pwr_wd ? ADCF_IDLE : ADCF_OFF; // R06 R07
                else if (wr_sts || sar_done)
                    state_nxt = wr_sts ? ADCF_BUSY : ADCF_IDLE;
            default:
                state_nxt = ADCF_OFF;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_r <= ADCF_OFF; // R20
            ctl_r <= `ADCF_CTL_RESET;
            irq_en_r <= 1'b0;
            done_r <= 1'b0;
            res_hi_r <= `ADCF_RES_RESET;
            res_lo_r <= `ADCF_RES_RESET;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            start_r <= 1'b0;
            abort_r <= 1'b0;
            irq_r <= 1'b0;
            pwr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            done_r <= done_nxt;
            wait_r <= !(req && wait_r);
            rdata_r <= {24'h00_0000, rd_byte};
            if (wr_ctl)
                ctl_r <= ctl_wd;
            if (wr_sts)
                irq_en_r <= ctl_wd[`ADCF_STS_IRQEN_BIT];
            if (finish)
            begin
                res_hi_r <= res_fmt[15:8]; // R01
                res_lo_r <= res_fmt[7:0];
            end
            start_r <= wr_sts && state_r != ADCF_OFF && !wr_ctl;
            abort_r <= state_r == ADCF_BUSY && (wr_ctl || wr_sts); // R06
            irq_r <= done_nxt && (wr_sts ? ctl_wd[`ADCF_STS_IRQEN_BIT] : irq_en_r); // R01 R02
            pwr_r <= wr_ctl ? pwr_wd : pwr_r;
        end
    end

    // Conversion clock: half period of prescale+1 bus cycles
    always_ff @(posedge core_clk)
    begin
        if (!rstn || !pwr_r)
        begin
            div_cnt_r <= 4'h0;
            cclk_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_wrap ? 4'h0 : div_cnt_r + 4'h1; // R18
            cclk_r <= div_wrap ? ~cclk_r : cclk_r;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign conv_start = start_r;
    assign conv_abort = abort_r;
    assign conv_clk = cclk_r;
    assign converter_power_on = pwr_r;
    assign conv_irq = irq_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    // Helper for the divider check
    // Half periods spanning a control write are not judged
    logic [5:0] half_cnt_r;
    logic half_ok_r;
    always_ff @(posedge core_clk)
    begin
        if (!rstn || !pwr_r || ctl_r != $past(ctl_r))
        begin
            half_cnt_r <= 6'h01;
            half_ok_r <= 1'b0;
        end
        else if (cclk_r != $past(cclk_r))
        begin
            half_cnt_r <= 6'h01;
            half_ok_r <= 1'b1;
        end
        else
            half_cnt_r <= half_cnt_r + 6'h01;
    end

    // ==========================================================
    // Flag, interrupt and format checks

    a_irq_follows_flag: assert property (@(posedge core_clk) disable iff (!rstn) // R02
        conv_irq == (done_r && irq_en_r)) else $error("interrupt does not track done flag and enable");
    a_finish_sets_flag: assert property (@(posedge core_clk) disable iff (!rstn) // R22
        finish |=> done_r) else $error("completion did not set done flag");
    a_result_loaded: assert property (@(posedge core_clk) disable iff (!rstn) // R01
        finish |=> {res_hi_r, res_lo_r} == $past(res_fmt)) else $error("result not loaded at completion");
    a_sts_write_clears: assert property (@(posedge core_clk) disable iff (!rstn) // R03
        (wr_sts && !finish) |=> !done_r && !conv_irq) else $error("status write did not clear flag");
    a_res_read_clears: assert property (@(posedge core_clk) disable iff (!rstn) // R04
        (rd_res && !finish) |=> !done_r) else $error("result read did not clear flag");
    a_ctl_write_idle: assert property (@(posedge core_clk) disable iff (!rstn) // R06
        wr_ctl |=> state_r != ADCF_BUSY && !conv_start) else $error("control write left conversion running");
    a_power_off: assert property (@(posedge core_clk) disable iff (!rstn) // R07
        (wr_ctl && !pwr_wd) |=> state_r == ADCF_OFF ##1 !converter_power_on) else $error("power off not honoured");
    a_right_just: assert property (@(posedge core_clk) disable iff (!rstn) // R21
        (finish && !ctl_r[`ADCF_CTL_EIGHT_BIT] && ctl_r[`ADCF_CTL_JUSTIFY_BIT]) |=> res_hi_r[7:2] == 6'h00)
        else $error("unused high bits not zero");
    a_eight_low_zero: assert property (@(posedge core_clk) disable iff (!rstn) // R10
        (finish && ctl_r[`ADCF_CTL_EIGHT_BIT]) |=> res_lo_r == 8'h00 && res_hi_r[5:0] == $past(sar_data[7:2]))
        else $error("8-bit result misplaced");
    a_clk_divide: assert property (@(posedge core_clk) disable iff (!rstn || !pwr_r) // R18
        $changed(cclk_r) && half_ok_r && $stable(ctl_r) |-> half_cnt_r == {2'b00, clock_prescale_select} + 6'h01)
        else $error("conversion clock half period wrong");
    a_wait_one: assert property (@(posedge core_clk) disable iff (!rstn)
        (req && avs_waitrequest) |=> !avs_waitrequest) else $error("waitrequest held more than one cycle");

    // ==========================================================
    // Start, abort, power and bus checks
    a_start_on_status: assert property (@(posedge core_clk) disable iff (!rstn) // R19
        (wr_sts && state_r != ADCF_OFF && !wr_ctl) |=> conv_start)
        else $error("status write did not start a conversion");

    a_start_source: assert property (@(posedge core_clk) disable iff (!rstn) // R06
        conv_start |-> $past(wr_sts) && !$past(wr_ctl))
        else $error("conversion started without a status write");

    a_abort_on_status: assert property (@(posedge core_clk) disable iff (!rstn) // R19
        (wr_sts && state_r == ADCF_BUSY) |=> conv_abort)
        else $error("status write in conversion did not abort");

    a_off_clock_low: assert property (@(posedge core_clk) disable iff (!rstn) // R07
        (!converter_power_on && !$past(converter_power_on)) |-> !conv_clk)
        else $error("conversion clock runs while powered down");

    a_off_no_start: assert property (@(posedge core_clk) disable iff (!rstn) // R07
        state_r == ADCF_OFF |=> !conv_start)
        else $error("conversion started while powered down");

    a_result_held: assert property (@(posedge core_clk) disable iff (!rstn) // R01
        !finish |=> $stable(res_hi_r) && $stable(res_lo_r))
        else $error("result changed without a completion");

    a_ctl_loaded: assert property (@(posedge core_clk) disable iff (!rstn) // R14
        wr_ctl |=> ctl_r == $past(ctl_wd))
        else $error("control write not loaded");

    a_done_holds: assert property (@(posedge core_clk) disable iff (!rstn) // R22
        (!finish && !wr_sts && !rd_res) |=> done_r == $past(done_r))
        else $error("done flag changed without cause");

    a_done_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
        (sar_done && state_r != ADCF_BUSY && !done_r) |=> !done_r)
        else $error("completion outside conversion set the flag");

    a_irq_needs_en: assert property (@(posedge core_clk) disable iff (!rstn) // R01
        !irq_en_r |-> !conv_irq)
        else $error("interrupt raised while disabled");

    a_readdata_upper: assert property (@(posedge core_clk) disable iff (!rstn)
        avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    a_wait_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !avs_waitrequest |-> $past(req))
        else $error("waitrequest low without a request");

    // ==========================================================
    // Coverage of the main scenarios

    c_irq_raised: cover property (@(posedge core_clk) disable iff (!rstn) finish && irq_en_r ##1 conv_irq);
    c_set_vs_clear: cover property (@(posedge core_clk) disable iff (!rstn) finish && rd_res);
    c_abort: cover property (@(posedge core_clk) disable iff (!rstn) state_r == ADCF_BUSY && wr_ctl);
    c_signed_left: cover property (@(posedge core_clk) disable iff (!rstn)
        finish && ctl_r[`ADCF_CTL_SIGNED_BIT] && !ctl_r[`ADCF_CTL_JUSTIFY_BIT]);
    c_power_down: cover property (@(posedge core_clk) disable iff (!rstn)
        state_r == ADCF_BUSY && wr_ctl && !pwr_wd);

endmodule // adcf_control

// File: sim/adcf_core_model.sv
// Behavioural conversion core: returns code lat+1 conv_clk rises after a start.
// Assumes start, abort and power come from the control block on core_clk.
`timescale 1ns/1ps
module adcf_core_model
    import adcf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic conv_clk,
    input wire logic converter_power_on,
    input wire logic [9:0] code,
    input wire logic [7:0] lat,
    output logic sar_done,
    output logic [9:0] sar_data
);
    logic busy_r, clk_q;
    logic [7:0] left_r;
    wire rise = conv_clk && !clk_q;
    // Data toggles outside the done pulse so stale codes never match
    always_ff @(posedge core_clk)
    begin
        clk_q <= conv_clk;
        sar_done <= 1'b0;
        sar_data <= rstn ? ~sar_data : 10'h000;
        if (!rstn || !converter_power_on || (conv_abort && !conv_start))
            busy_r <= 1'b0;
        else if (conv_start)
        begin
            busy_r <= 1'b1;
            left_r <= lat;
        end
        else if (busy_r && rise)
        begin
            left_r <= left_r - 8'h01;
            if (left_r == 8'h00)
            begin
                busy_r <= 1'b0;
                sar_done <= 1'b1;
                sar_data <= code;
            end
        end
    end
endmodule // adcf_core_model

// File: sim/tb_adc_control_and_result_format.sv
// Self-checking bench of the converter control block.
// Assumes adcf_control and the core model; Avalon-MM master driven here.
`timescale 1ns/1ps
module tb_adc_control_and_result_format
    import adcf_pkg::*;
;
    logic core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, sar_done, conv_start, conv_abort, conv_clk, converter_power_on, conv_irq;
    logic [9:0] sar_data, code = 10'h000;
    logic [7:0] lat = 8'h04, q;
    int failures = 0, comparisons = 0, aborts = 0;
    adcf_control uut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sar_done(sar_done), .sar_data(sar_data),
        .conv_start(conv_start), .conv_abort(conv_abort), .conv_clk(conv_clk),
        .converter_power_on(converter_power_on), .conv_irq(conv_irq));
    adcf_core_model core (.core_clk(core_clk), .rstn(rstn), .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_clk(conv_clk), .converter_power_on(converter_power_on), .code(code), .lat(lat),
        .sar_done(sar_done), .sar_data(sar_data));
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (conv_abort === 1'b1) aborts <= aborts + 1;
    // ==========
    // Helpers
    task wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(inout int n, input int lim);
        @(negedge core_clk);
        n++;
        if (n > lim)
        begin
            failures++;
            $display("CHECK FAILED wait bound expected %0d seen %0d", lim, n);
            wrap_up();
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // The completing edge is the one that samples waitrequest low
        do
        begin
            @(posedge core_clk);
            n++;
            if (n > 20)
            begin
                failures++;
                $display("CHECK FAILED bus wait expected %0d seen %0d", 20, n);
                wrap_up();
            end
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00, 4'hF);
    endtask
    task wait_irq;
        int n;
        n = 0;
        while (conv_irq !== 1'b1) tick(n, 3000);
    endtask
    function automatic logic [15:0] pair(input logic [7:0] ctl, input logic [9:0] c);
        logic [9:0] s;
        s = c;
        if (!ctl[6] && ctl[4]) s[9] = ~s[9];
        if (ctl[5]) return {s[9:2], 8'h00};
        if (ctl[6]) return {6'h00, c};
        return {s, 6'h00};
    endfunction
    // ==========
    // Scenarios
    task t_reset;
        for (int i = 0; i < 5; i++)
        begin
            rd(i == 4 ? 4'h2 : 4'(i * 4));
            check("reset read", {8'h00, q}, 16'h0000);
        end
        // Byte lane 0 off: write must be dropped
        bus(1'b1, 4'h0, 8'h80, 4'h0);
        @(negedge core_clk);
        check("power", converter_power_on, 1'b0);
        check("irq", conv_irq, 1'b0);
        $display("test reset done");
    endtask
    task t_formats;
        logic [9:0] codes [3] = '{10'h3FF, 10'h000, 10'h2A5};
        logic [7:0] ctl;
        logic [15:0] e;
        for (int m = 0; m < 8; m++)
            for (int k = 0; k < 3; k++)
            begin
                ctl = 8'h80 | 8'(m << 4);
                code <= codes[k];
                e = pair(ctl, codes[k]);
                wr(4'h0, ctl);
                wr(4'h4, 8'h40);
                wait_irq();
                rd(4'h8);
                check("hi", {8'h00, q}, {8'h00, e[15:8]});
                repeat (2) @(negedge core_clk);
                check("irq after read", conv_irq, 1'b0);
                rd(4'hC);
                check("lo", {8'h00, q}, {8'h00, e[7:0]});
            end
        $display("test formats done");
    endtask
    task t_restart;
        wr(4'h4, 8'h40);
        wait_irq();
        wr(4'h4, 8'h40);
        repeat (2) @(negedge core_clk);
        check("irq cancelled", conv_irq, 1'b0);
        wait_irq();
        rd(4'h4);
        check("status", {8'h00, q}, 16'h00C0);
        $display("test restart done");
    endtask
    task t_poll;
        int n;
        n = 0;
        wr(4'h4, 8'h00);
        do
        begin
            rd(4'h4);
            tick(n, 200);
        end
        while (q[7] !== 1'b1);
        check("irq disabled", conv_irq, 1'b0);
        wr(4'h4, 8'h00);
        rd(4'h4);
        check("status cleared", {8'h00, q}, 16'h0000);
        $display("test poll done");
    endtask
    task t_abort;
        int n0;
        for (int i = 0; i < 2; i++)
        begin
            wr(4'h0, 8'h80);
            wr(4'h4, 8'h40);
            repeat (2) @(negedge core_clk);
            n0 = aborts;
            wr(4'h0, i == 0 ? 8'h80 : 8'h00);
            repeat (100) @(negedge core_clk);
            check("abort", 16'(aborts - n0), 16'h0001);
            check("power", converter_power_on, i == 0);
            check("no completion", conv_irq, 1'b0);
        end
        $display("test abort done");
    endtask
    task t_prescale;
        int n;
        for (int p = 0; p < 16; p += 5)
        begin
            wr(4'h0, 8'h80 | 8'(p));
            n = 0;
            while (conv_clk !== 1'b0) tick(n, 100);
            while (conv_clk !== 1'b1) tick(n, 100);
            n = 0;
            while (conv_clk !== 1'b0) tick(n, 100);
            while (conv_clk !== 1'b1) tick(n, 100);
            check("clock period", 16'(n), 16'(2 * p + 2));
        end
        $display("test prescale done");
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_formats();
        lat <= 8'h14;
        t_restart();
        t_poll();
        t_abort();
        t_prescale();
        wrap_up();
    end
endmodule // tb_adc_control_and_result_format
